// File: tb/pwm_bridge_model.sv
// period generator and bridge driver side of the pwm stage
// assumes the same clk as the controller; half-bridge pattern
`timescale 1ns/1ps
`default_nettype none
module pwm_bridge_model #(
  parameter int PERIOD = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] duty,
  output logic period_start,
  output pwm_shutdown_pkg::pin_vec_t pwm_sched,
  input wire pwm_shutdown_pkg::pin_vec_t output_pin_out,
  input wire pwm_shutdown_pkg::pin_vec_t output_pin_oe,
  output pwm_shutdown_pkg::pin_vec_t bridge_level
);
  import pwm_shutdown_pkg::*;
  logic [7:0] cnt_q;
  logic act;
  // free-running period count
  always_ff @(posedge clk) begin
    if (reset || cnt_q == 8'(PERIOD - 1)) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  // a/c modulated, b/d complementary
  assign period_start = !reset && cnt_q == 8'h00;
  assign act = cnt_q < duty;
  assign pwm_sched = {~act, act, ~act, act};
  // switch inputs carry pull-downs, so an undriven pin reads low
  assign bridge_level = output_pin_out & output_pin_oe;
endmodule : pwm_bridge_model
`default_nettype wire

// File: tb/pwm_shutdown_chk.sv
// port checker for the pwm shutdown and dead-band controller
// assumes a bind onto the top module, one clk domain
`timescale 1ns/1ps
`default_nettype none
module pwm_shutdown_chk (
  input wire logic clk,
  input wire logic reset,
  input wire pwm_shutdown_pkg::reg_addr_t addr,
  input wire pwm_shutdown_pkg::reg_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire pwm_shutdown_pkg::reg_byte_t rdata,
  input wire logic period_start,
  input wire pwm_shutdown_pkg::pin_vec_t pin_output_enable,
  input wire logic comparator_1,
  input wire logic comparator_2,
  input wire logic fault_input_pin,
  input wire pwm_shutdown_pkg::pin_vec_t output_pin_out,
  input wire pwm_shutdown_pkg::pin_vec_t output_pin_oe,
  input wire logic period_timer_flag
);
  import pwm_shutdown_pkg::*;
  // ----
  // shadow of source select and safe codes
  // ----
  logic [6:0] ctl_q;
  logic [3:0] live_q;
  logic cause;
  assign cause = |(ctl_q[6:4] & {fault_input_pin, comparator_2, comparator_1});
  // fields land on the write edge, as in the real register
  always_ff @(posedge clk) begin
    if (reset) ctl_q <= 7'h00;
    else if (wr && addr == 4'h1) ctl_q <= wdata[6:0];
  end
  // how long the selected cause has stood; saturates so it never wraps
  always_ff @(posedge clk) begin
    if (reset || !cause) live_q <= 4'h0;
    else if (live_q != 4'hf) live_q <= live_q + 4'h1;
  end
  function automatic logic pair_ok(logic [1:0] c, logic [1:0] o, logic [1:0] e);
    return c[1] ? (e == 2'b00) : (o == {2{c[0]}});
  endfunction : pair_ok
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_safe_async: assert property (cause |->
    pair_ok(ctl_q[3:2], {output_pin_out[2], output_pin_out[0]},
    {output_pin_oe[2], output_pin_oe[0]}) && pair_ok(ctl_q[1:0],
    {output_pin_out[3], output_pin_out[1]}, {output_pin_oe[3], output_pin_oe[1]}))
    else $error("safe state not driven");
  a_oe_gated: assert property ((output_pin_oe & ~pin_output_enable) == 4'h0)
    else $error("pin enabled while direction is input");
  a_flag_set: assert property (period_start |=> period_timer_flag)
    else $error("period flag missed");
  a_flag_clear: assert property (wr && addr == 4'h3 && !wdata[0] && !period_start
    |=> !period_timer_flag) else $error("period flag not cleared");
  a_flag_hold: assert property (period_timer_flag && !(wr && addr == 4'h3)
    |=> period_timer_flag) else $error("period flag dropped");
  a_status_live: assert property (rd && addr == 4'h1 && live_q > 4'h4
    |=> rdata[7]) else $error("status clear under live cause");
  a_cond_seen: assert property (rd && addr == 4'h3 && live_q > 4'h4
    |=> rdata[1]) else $error("live cause not reported");
  a_resume_edge: assert property ($rose(output_pin_oe[0]) && $past(pin_output_enable[0])
    && $stable(ctl_q[3:2]) && $past(ctl_q[3]) |-> $past(period_start))
    else $error("restart away from period start");
  c_shut: cover property (cause && ctl_q[3]);
  c_held: cover property (period_start && !output_pin_oe[0] && pin_output_enable[0]);
  c_live: cover property (rd && addr == 4'h1 && live_q > 4'h4);
endmodule : pwm_shutdown_chk
`default_nettype wire

// File: tb/pwm_shutdown_deadband_ctrl_tb.sv
// self-checking bench for the pwm shutdown and dead-band controller
// assumes the bridge model supplies period starts and scheduled levels
`timescale 1ns/1ps
`default_nettype none
module pwm_shutdown_deadband_ctrl_tb;
  import pwm_shutdown_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  reg_addr_t addr = 4'h0;
  reg_byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] src = 3'h0;
  pin_vec_t pin_oe = 4'h0; // pins start as inputs
  reg_byte_t rdata;
  logic period_start;
  logic flag;
  pin_vec_t sched;
  pin_vec_t pout;
  pin_vec_t poe;
  pin_vec_t level;
  int n_errors = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  pwm_shutdown_deadband_ctrl pwm_shutdown_deadband_ctrl_inst (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .period_start(period_start), .pwm_sched(sched), .pin_output_enable(pin_oe),
    .comparator_1(src[0]), .comparator_2(src[1]), .fault_input_pin(src[2]),
    .output_pin_out(pout), .output_pin_oe(poe), .period_timer_flag(flag));
  pwm_bridge_model #(.PERIOD(40)) pwm_bridge_model_inst (.clk(clk), .reset(reset),
    .duty(8'h14), .period_start(period_start), .pwm_sched(sched),
    .output_pin_out(pout), .output_pin_oe(poe), .bridge_level(level));
  // ----
  // bus cycles and compares
  // ----
  task automatic chk_reg(input reg_byte_t got, input reg_byte_t exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input pin_vec_t got, input pin_vec_t exp);
    chk_reg({4'h0, got}, {4'h0, exp});
  endtask : chk_pin
  task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // the period flag moves on its own, so status reads skip bit 0
  task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_reg(rdata & (a == 4'h3 ? 8'h06 : 8'hff), e);
  endtask : rd_chk
  task automatic wait_start();
    do @(posedge clk); while (period_start !== 1'b1);
  endtask : wait_start
  // sources off, status cleared, outputs back at a period start
  task automatic recover();
    repeat (5) @(posedge clk);
    src <= 3'h0;
    repeat (4) @(posedge clk);
    wr_reg(4'h1, 8'h0a);
    wait_start();
    repeat (2) @(posedge clk);
  endtask : recover
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    for (int a = 0; a < 5; a++) rd_chk(4'(a == 4 ? 12 : a), 8'h00);
    wr_reg(4'h0, 8'h85);
    wr_reg(4'hc, 8'hff);
    rd_chk(4'hc, 8'h00);
    rd_chk(4'h0, 8'h85);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_setup();
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h2, 8'h02);
    wr_reg(4'h0, 8'h03);
    wr_reg(4'h1, 8'h8a);
    wr_reg(4'h3, 8'h00);
    wait_start();
    #1 chk_pin({3'h0, flag}, 4'h1);
    @(posedge clk);
    pin_oe <= 4'hf;
    #1 chk_pin(poe, 4'h0);
    wr_reg(4'h1, 8'h0a);
    wait_start();
    repeat (2) @(posedge clk);
    #1 chk_pin(poe, 4'hf);
    $display("t_setup done");
  endtask : t_setup
  task automatic t_dead();
    int n;
    logic seen;
    do @(negedge clk); while (sched[1] !== 1'b0);
    do @(negedge clk); while (sched[1] !== 1'b1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pout[1] !== 1'b1 && n < 99);
    chk_reg(8'(n >= 10 && n <= 15), 8'h01);
    chk_pin(pout, 4'hf);
    wr_reg(4'h0, 8'h7f);
    do @(negedge clk); while (sched[1] !== 1'b0);
    repeat (3) @(negedge clk);
    seen = 1'b0;
    repeat (120) begin
      @(negedge clk);
      seen |= pout[1];
    end
    chk_reg({7'h0, seen}, 8'h00);
    chk_pin(pout, 4'h5);
    @(posedge clk);
    pin_oe <= 4'h0;
    wr_reg(4'h2, 8'h01);
    @(posedge clk);
    #1 chk_pin(pout, 4'ha);
    wr_reg(4'h2, 8'h02);
    pin_oe <= 4'hf;
    $display("t_dead done");
  endtask : t_dead
  task automatic t_auto();
    wr_reg(4'h0, 8'h80);
    wr_reg(4'h1, 8'h19);
    @(posedge clk);
    src <= 3'h1;
    #1 chk_pin(level, 4'ha);
    repeat (6) @(posedge clk);
    rd_chk(4'h1, 8'h99);
    rd_chk(4'h3, 8'h06);
    wr_reg(4'h1, 8'h19);
    rd_chk(4'h1, 8'h99);
    wait_start();
    src <= 3'h0;
    repeat (5) @(posedge clk);
    rd_chk(4'h1, 8'h19);
    chk_pin(poe, 4'ha);
    wait_start();
    repeat (2) @(posedge clk);
    #1 chk_pin(poe, 4'hf);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_manual();
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h44);
    @(posedge clk);
    src <= 3'h4;
    repeat (5) @(posedge clk);
    src <= 3'h0;
    repeat (6) @(posedge clk);
    rd_chk(4'h1, 8'hc4);
    wr_reg(4'h1, 8'h44);
    rd_chk(4'h1, 8'h44);
    wait_start();
    wr_reg(4'h1, 8'hc4);
    @(posedge clk);
    #1 chk_pin(level, 4'h5);
    recover();
    $display("t_manual done");
  endtask : t_manual
  task automatic t_codes();
    wr_reg(4'h0, 8'h80);
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 3; s++) begin
        wr_reg(4'h1, {1'b0, 3'(c), 4'ha});
        @(posedge clk);
        src <= 3'(1 << s);
        #1 chk_pin(poe, c[s] ? 4'h0 : 4'hf);
        recover();
      end
    end
    $display("t_codes done");
  endtask : t_codes
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_setup();
    t_dead();
    t_auto();
    t_manual();
    t_codes();
    wrap_up();
  end
  // roughly ten times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule : pwm_shutdown_deadband_ctrl_tb
bind pwm_shutdown_deadband_ctrl pwm_shutdown_chk pwm_shutdown_chk_inst (.clk(clk),
  .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .period_start(period_start), .pin_output_enable(pin_output_enable),
  .comparator_1(comparator_1), .comparator_2(comparator_2),
  .fault_input_pin(fault_input_pin), .output_pin_out(output_pin_out),
  .output_pin_oe(output_pin_oe), .period_timer_flag(period_timer_flag));
`default_nettype wire

// File: verilog/dead_band_delay.sv
// per-output turn-on delay counted in instruction cycles
// assumes instr_en is a one-cycle pulse every instruction cycle
`timescale 1ns/1ps
`default_nettype none
module dead_band_delay #(
  parameter int CHANNELS = 4,
  parameter int COUNT_W = 7
) (
  input wire logic clk,
  input wire logic reset,
  dead_band_if.delay db
);
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_chan
      logic [COUNT_W-1:0] wait_q;
      logic delayed_q;
      // count restarts whenever the scheduled level drops
      always_ff @(posedge clk) begin
        if (reset) begin
          wait_q <= '0;
        end else if (!db.sched[i]) begin
          wait_q <= '0;
        end else if (db.instr_en && (wait_q < db.count)) begin
          wait_q <= wait_q + 1'b1;
        end
      end
      // turn-on only after the full count; turn-off follows at once
      // a count longer than the active time keeps the output off
      always_ff @(posedge clk) begin
        if (reset) begin
          delayed_q <= 1'b0;
        end else begin
          delayed_q <= db.sched[i] && (wait_q >= db.count);
        end
      end
      assign db.delayed[i] = delayed_q;
    end
  endgenerate
endmodule : dead_band_delay
`default_nettype wire

// File: verilog/dead_band_if.sv
// carrier between the controller and its dead-band delay lines
// assumes both ends run on the same clk
`timescale 1ns/1ps
`default_nettype none
interface dead_band_if;
  logic instr_en;
  pwm_shutdown_pkg::dead_count_t count;
  pwm_shutdown_pkg::pin_vec_t sched;
  pwm_shutdown_pkg::pin_vec_t delayed;
  modport ctrl (output instr_en, output count, output sched, input delayed);
  modport delay (input instr_en, input count, input sched, output delayed);
endinterface : dead_band_if
`default_nettype wire

// File: verilog/level_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs come from pins outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync
`default_nettype wire

// File: verilog/pwm_shutdown_deadband_ctrl.sv
// auto-shutdown, auto-restart, polarity and dead-band control of a
// four-output pwm stage (pairs a/c and b/d)
// assumes the period generator supplies scheduled levels and a period
// start pulse on clk, and that clk is the oscillator clock
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_shutdown_defs.svh"
module pwm_shutdown_deadband_ctrl #(
  parameter int CHANNELS = 4,
  parameter int COUNT_W = 7
) (
  input wire logic clk,
  input wire logic reset,
  input wire pwm_shutdown_pkg::reg_addr_t addr,
  input wire pwm_shutdown_pkg::reg_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output pwm_shutdown_pkg::reg_byte_t rdata,
  input wire logic period_start,
  input wire pwm_shutdown_pkg::pin_vec_t pwm_sched,
  input wire pwm_shutdown_pkg::pin_vec_t pin_output_enable,
  input wire logic comparator_1,
  input wire logic comparator_2,
  input wire logic fault_input_pin,
  output pwm_shutdown_pkg::pin_vec_t output_pin_out,
  output pwm_shutdown_pkg::pin_vec_t output_pin_oe,
  output logic period_timer_flag
);
  import pwm_shutdown_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [1:0] div_q;
  logic instr_en;
  logic [2:0] src_sync;
  logic auto_restart_enable_q;
  dead_count_t dead_band_count_q;
  logic shutdown_event_status_q;
  logic [2:0] shutdown_source_select_q;
  logic [1:0] pair_ac_shutdown_state_q;
  logic [1:0] pair_bd_shutdown_state_q;
  logic [3:0] mode_polarity_q;
  logic period_timer_flag_q;
  logic wr_del;
  logic wr_as;
  logic wr_mode;
  logic wr_stat;
  logic cond_sync;
  logic cond_raw;
  logic shut_active;
  shutdown_state_t state_q;
  shutdown_state_t state_d;
  pin_vec_t norm_q;
  reg_byte_t rd_value;
  reg_byte_t rdata_q;

  dead_band_if db ();

  // ----------------------------------------------------------------------
  // instruction-cycle enable
  // ----------------------------------------------------------------------
  // one pulse every four clk periods; the dead-band counts these
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= '0;
    end else if (div_q == 2'(`INSTR_DIV_LAST)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign instr_en = (div_q == 2'(`INSTR_DIV_LAST));

  // ----------------------------------------------------------------------
  // shutdown sources
  // ----------------------------------------------------------------------
  // bit order: 0 comparator 1, 1 comparator 2, 2 fault pin
  level_sync #(
    .WIDTH(3)
  ) u_src_sync (
    .clk(clk),
    .reset(reset),
    .async_in({fault_input_pin, comparator_2, comparator_1}),
    .sync_out(src_sync)
  );

  // each select bit enables one source; codes OR them together
  assign cond_sync = |(shutdown_source_select_q & src_sync);

  // raw path feeds the pin override and, through the held bit of the status read, the read flop
  assign cond_raw = |(shutdown_source_select_q &
                     {fault_input_pin, comparator_2, comparator_1});

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  // one strobe per mapped offset; unmapped writes fall through
  always_comb begin
    wr_del = 1'b0;
    wr_as = 1'b0;
    wr_mode = 1'b0;
    wr_stat = 1'b0;
    if (wr && (addr == `OFS_DEAD_BAND_RESTART)) begin
      wr_del = 1'b1;
    end else if (wr && (addr == `OFS_SHUTDOWN_CONTROL)) begin
      wr_as = 1'b1;
    end else if (wr && (addr == `OFS_MODE_POLARITY)) begin
      wr_mode = 1'b1;
    end else if (wr && (addr == `OFS_STATUS)) begin
      wr_stat = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // dead-band / restart register
  // ----------------------------------------------------------------------
  // restart enable and count share one byte
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_restart_enable_q <= 1'(`RST_DEAD_BAND_RESTART >> `BIT_AUTO_RESTART);
      dead_band_count_q <= dead_count_t'(`RST_DEAD_BAND_RESTART);
    end else if (wr_del) begin
      auto_restart_enable_q <= wdata[`BIT_AUTO_RESTART];
      dead_band_count_q <= wdata[COUNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // shutdown control register: source select and safe states
  // ----------------------------------------------------------------------
  // source select and both pair safe codes are written together
  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown_source_select_q <= 3'(`RST_SHUTDOWN_CONTROL >> `LSB_SOURCE_SEL);
      pair_ac_shutdown_state_q <= 2'(`RST_SHUTDOWN_CONTROL >> `LSB_AC_STATE);
      pair_bd_shutdown_state_q <= 2'(`RST_SHUTDOWN_CONTROL);
    end else if (wr_as) begin
      shutdown_source_select_q <= wdata[`MSB_SOURCE_SEL:`LSB_SOURCE_SEL];
      pair_ac_shutdown_state_q <= wdata[`MSB_AC_STATE:`LSB_AC_STATE];
      pair_bd_shutdown_state_q <= wdata[`MSB_BD_STATE:`LSB_BD_STATE];
    end
  end

  // ----------------------------------------------------------------------
  // shutdown event status
  // ----------------------------------------------------------------------
  // a live cause always wins, so a clear in the same cycle is lost and
  // a comparator level keeps the bit pinned until it drops
  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown_event_status_q <= 1'b0;
    end else if (cond_sync) begin
      shutdown_event_status_q <= 1'b1;
    end else if (wr_as && wdata[`BIT_EVENT_STATUS]) begin
      shutdown_event_status_q <= 1'b1;
    end else if (wr_as) begin
      shutdown_event_status_q <= 1'b0;
    end else if (auto_restart_enable_q) begin
      shutdown_event_status_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // output hold sequence
  // ----------------------------------------------------------------------
  // restart waits for a period edge so no partial pulse leaves the pins
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_running: begin
        if (shutdown_event_status_q) begin
          state_d = st_shut;
        end
      end
      st_shut: begin
        if (!shutdown_event_status_q) begin
          state_d = st_resume_wait;
        end
      end
      st_resume_wait: begin
        if (shutdown_event_status_q) begin
          state_d = st_shut;
        end else if (period_start) begin
          state_d = st_running;
        end
      end
      default: begin
        state_d = st_shut;
      end
    endcase
  end

  // sequence register; reset leaves the outputs running
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= st_running;
    end else begin
      state_q <= state_d;
    end
  end

  // held off by the raw pins at once, then by status and the sequence
  assign shut_active = cond_raw || shutdown_event_status_q ||
                       (state_q != st_running);

  // ----------------------------------------------------------------------
  // mode / polarity register
  // ----------------------------------------------------------------------
  // bits 3:2 hold the output configuration for readback only
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_polarity_q <= `RST_MODE_POLARITY;
    end else if (wr_mode) begin
      mode_polarity_q <= wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // period timer flag
  // ----------------------------------------------------------------------
  // the first period edge after start marks one full cycle done;
  // a period edge beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      period_timer_flag_q <= 1'b0;
    end else if (period_start) begin
      period_timer_flag_q <= 1'b1;
    end else if (wr_stat && !wdata[`BIT_PERIOD_FLAG]) begin
      period_timer_flag_q <= 1'b0;
    end
  end

  // flag leaves straight from its flop
  assign period_timer_flag = period_timer_flag_q;

  // ----------------------------------------------------------------------
  // dead-band delay lines
  // ----------------------------------------------------------------------
  // the count is applied in every mode; half-bridge use is up to firmware
  assign db.instr_en = instr_en;
  assign db.count = dead_band_count_q;
  assign db.sched = pwm_sched;

  dead_band_delay #(
    .CHANNELS(CHANNELS),
    .COUNT_W(COUNT_W)
  ) u_dead_band (
    .clk(clk),
    .reset(reset),
    .db(db)
  );

  // ----------------------------------------------------------------------
  // polarity and pin drive
  // ----------------------------------------------------------------------
  // even index is pair a/c, odd index pair b/d; polarity changes while
  // pins drive will glitch them, so firmware sets it first
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_pin
      logic invert;
      logic [1:0] safe;
      assign invert = ((i % 2) == 0) ? mode_polarity_q[`BIT_POL_AC_LOW]
                                     : mode_polarity_q[`BIT_POL_BD_LOW];
      assign safe = ((i % 2) == 0) ? pair_ac_shutdown_state_q
                                   : pair_bd_shutdown_state_q;
      // normal level passes one flop after the dead-band line
      always_ff @(posedge clk) begin
        if (reset) begin
          norm_q[i] <= 1'b0;
        end else begin
          norm_q[i] <= db.delayed[i] ^ invert;
        end
      end
      // safe level ignores polarity; 1x releases the pin
      assign output_pin_out[i] = shut_active ? (safe == `SAFE_DRIVE_HIGH)
                                             : norm_q[i];
      assign output_pin_oe[i] = pin_output_enable[i] &&
                                !(shut_active && safe[1]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_value = '0;
    if (addr == `OFS_DEAD_BAND_RESTART) begin
      rd_value = {auto_restart_enable_q, dead_band_count_q};
    end else if (addr == `OFS_SHUTDOWN_CONTROL) begin
      rd_value = {shutdown_event_status_q, shutdown_source_select_q,
                  pair_ac_shutdown_state_q, pair_bd_shutdown_state_q};
    end else if (addr == `OFS_MODE_POLARITY) begin
      rd_value = {4'h0, mode_polarity_q};
    end else if (addr == `OFS_STATUS) begin
      rd_value[`BIT_PERIOD_FLAG] = period_timer_flag_q;
      rd_value[`BIT_COND_LIVE] = cond_sync;
      rd_value[`BIT_OUT_HELD] = shut_active;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (rd) begin
      rdata_q <= rd_value;
    end else begin
      rdata_q <= '0;
    end
  end

  // rdata comes from a flop, so it idles at zero between reads
  assign rdata = rdata_q;
endmodule : pwm_shutdown_deadband_ctrl
`default_nettype wire

// File: verilog/pwm_shutdown_defs.svh
// constants for the pwm shutdown and dead-band controller: offsets, fields, resets, timing
// assumes inclusion by bare name from the design files only
`ifndef PWM_SHUTDOWN_DEFS_SVH
`define PWM_SHUTDOWN_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_DEAD_BAND_RESTART 4'h0
`define OFS_SHUTDOWN_CONTROL 4'h1
`define OFS_MODE_POLARITY 4'h2
`define OFS_STATUS 4'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_AUTO_RESTART 7
`define BIT_EVENT_STATUS 7
`define MSB_SOURCE_SEL 6
`define LSB_SOURCE_SEL 4
`define MSB_AC_STATE 3
`define LSB_AC_STATE 2
`define MSB_BD_STATE 1
`define LSB_BD_STATE 0
`define BIT_POL_AC_LOW 1
`define BIT_POL_BD_LOW 0
`define BIT_PERIOD_FLAG 0
`define BIT_COND_LIVE 1
`define BIT_OUT_HELD 2

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define RST_DEAD_BAND_RESTART 8'h00
`define RST_SHUTDOWN_CONTROL 8'h00
`define RST_MODE_POLARITY 4'h0
`define SAFE_DRIVE_HIGH 2'h1

// ----------------------------------------------------------------------
// timing: one instruction cycle is four oscillator (clk) periods
// ----------------------------------------------------------------------
`define INSTR_CYCLE_OSC 4
`define INSTR_DIV_LAST (`INSTR_CYCLE_OSC - 1)

`endif

// File: verilog/pwm_shutdown_pkg.sv
// types shared by the pwm shutdown and dead-band controller
// assumes nothing beyond a sv compiler
package pwm_shutdown_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] pin_vec_t;
  typedef logic [6:0] dead_count_t;
  // output hold sequence around a shutdown
  typedef enum logic [1:0] {
    st_running,
    st_shut,
    st_resume_wait
  } shutdown_state_t;
endpackage : pwm_shutdown_pkg
